// file: cidd_defs.vh
`ifndef CIDD_DEFS_VH
`define CIDD_DEFS_VH

// Full 14-bit opcodes
`define CIDD_OP_BRW 14'h000B
`define CIDD_OP_CALL_BY_ACCUMULATOR 14'h000A
`define CIDD_OP_OPTION 14'h0062
`define CIDD_OP_SLEEP 14'h0063
`define CIDD_OP_CLRWDT 14'h0064

// Prefixes matched on the top bits of the opcode
`define CIDD_PFX6_RETURN_WITH_LITERAL 6'h34
`define CIDD_PFX6_AND_IMMEDIATE 6'h39
`define CIDD_PFX6_ADD_IMMEDIATE 6'h3E
`define CIDD_PFX6_AND_WITH_FILE 6'h05
`define CIDD_PFX7_ADDFP 7'h62
`define CIDD_PFX7_LDIDX 7'h7E
`define CIDD_PFX7_STIDX 7'h7F
`define CIDD_PFX10_MODPTR 10'h001
`define CIDD_PFX11_PORT_DIRECTION_REGISTER 11'h00C

// Field positions
`define CIDD_LIT_HI 7
`define CIDD_K6_HI 5
`define CIDD_K6_SIGN 5
`define CIDD_SEL_IDX 6
`define CIDD_SEL_MOD 2
`define CIDD_STORE_BIT 3
`define CIDD_DEST_BIT 7
`define CIDD_FILE_HI 6
`define CIDD_PORT_DIRECTION_REGISTER_HI 2
`define CIDD_NIB_HI 3
`define CIDD_PMEM_BIT 15

// Pre/post modify codes
`define CIDD_MM_PREINC 2'h0
`define CIDD_MM_PREDEC 2'h1
`define CIDD_MM_POSTINC 2'h2
`define CIDD_MM_POSTDEC 2'h3

// Reset values
`define CIDD_RST_BYTE 8'h00
`define CIDD_RST_PTR 16'h0000
`define CIDD_RST_PRESC 8'hFF
`define CIDD_RST_PORT_DIRECTION_REGISTER 8'hFF
`define CIDD_ONE16 16'h0001

`endif

// file: cidd_core.v
// Summary of operation
// - branch_by_accumulator jumps relative by W, two cycles
// - call_by_accumulator pushes return, jumps via W
// - return_with_literal loads W and pops, two cycles
// - Copy W to prescaler config, flags untouched
// - Copy W to selected port direction register
// - Standby entry updates timeout and powerdown flags
// - add_to_pointer selects pointer, 6-bit literal, one cycle
// - Literal sign-extended, added to 16-bit pointer, no flags
// - Pointer arithmetic wraps modulo 65536, no fault
// - pointer_load with modify loads W, updates zero
// - Indexed pointer_load reads pointer plus offset
// - pointer_store with modify writes W, no flags
// - Indexed pointer_store writes W at pointer plus offset
// - PC change or true skip costs extra nop cycle
// - Program-memory indirect access adds one cycle
// - and_immediate ANDs literal into W, zero only
// - add_immediate adds literal, updates carry, digit carry, zero
// - and_with_file ANDs W with f, d picks destination
`timescale 1ns/10ps
`include "cidd_defs.vh"

module cidd_core #(
  parameter PC_W = 15,
  parameter SP_W = 4,
  parameter PORT_DIRECTION_REGISTER_N = 8
) (
  input wire clock,
  input wire rst,
  input wire instr_valid,
  input wire [13:0] instr,
  output wire instr_ready,
  input wire other_two_cycle,
  input wire [6:0] pc_latch,
  input wire wake,
  input wire [7:0] mem_rdata,
  output wire [15:0] mem_addr,
  output wire [7:0] mem_wdata,
  output wire mem_re,
  output wire mem_we,
  output wire mem_prog,
  output reg [PC_W-1:0] pc,
  output reg [7:0] w_reg,
  output reg carry_flag,
  output reg digit_carry_flag,
  output reg zero_flag,
  output reg timeout_flag,
  output reg powerdown_flag,
  output reg standby,
  output reg [15:0] fsr0,
  output reg [15:0] fsr1,
  output reg [7:0] prescaler_cfg,
  output wire [8*PORT_DIRECTION_REGISTER_N-1:0] port_dir_flat
);

  localparam ST_RUN = 3'h1;
  localparam ST_NOP = 3'h2;
  localparam ST_PMEM = 3'h4;
  localparam [SP_W-1:0] SP_ONE = 1;
  localparam [PC_W-1:0] PC_ONE = 1;

  reg [2:0] state;
  reg [PC_W-1:0] stack [0:(1<<SP_W)-1];
  reg [SP_W-1:0] sp;
  reg [7:0] port_dir [0:PORT_DIRECTION_REGISTER_N-1];
  reg [15:0] pend_addr;
  reg pend_load;

  wire take = instr_valid && instr_ready;
  wire [7:0] lit8 = instr[`CIDD_LIT_HI:0];
  wire [5:0] k6 = instr[`CIDD_K6_HI:0];
  wire [15:0] k6_sext = {{10{k6[`CIDD_K6_SIGN]}}, k6};
  wire sel = instr[`CIDD_SEL_IDX];
  wire sel_mod = instr[`CIDD_SEL_MOD];
  wire [1:0] mm = instr[1:0];
  wire [PC_W-1:0] pc_inc = pc + PC_ONE;
  wire [PC_W-1:0] w_ext = {{(PC_W-8){1'b0}}, w_reg};

  wire is_brw = instr == `CIDD_OP_BRW;
  wire is_call_by_accumulator = instr == `CIDD_OP_CALL_BY_ACCUMULATOR;
  wire is_option = instr == `CIDD_OP_OPTION;
  wire is_sleep = instr == `CIDD_OP_SLEEP;
  wire is_return_with_literal = instr[13:8] == `CIDD_PFX6_RETURN_WITH_LITERAL;
  wire is_and_immediate = instr[13:8] == `CIDD_PFX6_AND_IMMEDIATE;
  wire is_add_immediate = instr[13:8] == `CIDD_PFX6_ADD_IMMEDIATE;
  wire is_and_with_file = instr[13:8] == `CIDD_PFX6_AND_WITH_FILE;
  wire is_addfp = instr[13:7] == `CIDD_PFX7_ADDFP;
  wire is_ldidx = instr[13:7] == `CIDD_PFX7_LDIDX;
  wire is_stidx = instr[13:7] == `CIDD_PFX7_STIDX;
  wire is_modptr = instr[13:4] == `CIDD_PFX10_MODPTR;
  wire is_ldmod = is_modptr && !instr[`CIDD_STORE_BIT];
  wire is_stmod = is_modptr && instr[`CIDD_STORE_BIT];
  wire is_clrwdt = instr == `CIDD_OP_CLRWDT;
  // Option, standby and watchdog clear share the prefix and win over the direction copy
  wire is_port_direction_register = instr[13:3] == `CIDD_PFX11_PORT_DIRECTION_REGISTER && !is_option && !is_sleep && !is_clrwdt;

  // Pointer selected by the instruction
  wire mod_sel = is_modptr ? sel_mod : sel;
  wire [15:0] ptr_cur = mod_sel ? fsr1 : fsr0;

  reg [15:0] ptr_new;
  reg [15:0] eff_addr;
  reg ptr_write;
  always @* begin
    ptr_new = ptr_cur;
    eff_addr = ptr_cur;
    ptr_write = 1'b0;
    if (is_addfp) begin
      ptr_new = ptr_cur + k6_sext;
      ptr_write = 1'b1;
    end else if (is_modptr) begin
      ptr_write = 1'b1;
      case (mm)
        `CIDD_MM_PREINC: begin
          ptr_new = ptr_cur + `CIDD_ONE16;
          eff_addr = ptr_new;
        end
        `CIDD_MM_PREDEC: begin
          ptr_new = ptr_cur - `CIDD_ONE16;
          eff_addr = ptr_new;
        end
        `CIDD_MM_POSTINC: ptr_new = ptr_cur + `CIDD_ONE16;
        `CIDD_MM_POSTDEC: ptr_new = ptr_cur - `CIDD_ONE16;
        default: ptr_new = ptr_cur;
      endcase
    end else if (is_ldidx || is_stidx) begin
      eff_addr = ptr_cur + k6_sext;
    end
  end

  wire is_ind = is_ldmod || is_stmod || is_ldidx || is_stidx;
  wire is_load = is_ldmod || is_ldidx;
  wire is_store = is_stmod || is_stidx;
  wire to_pmem = is_ind && eff_addr[`CIDD_PMEM_BIT];
  wire pc_mod = is_brw || is_call_by_accumulator || is_return_with_literal;

  // Memory port: indirect data access, file access, or held program read
  wire run = state == ST_RUN && take;
  wire pmem_rd = state == ST_PMEM && pend_load;
  wire [15:0] file_addr = {9'h000, instr[`CIDD_FILE_HI:0]};
  assign mem_addr = pmem_rd ? pend_addr : (is_and_with_file ? file_addr : eff_addr);
  assign mem_prog = pmem_rd || (run && to_pmem);
  assign mem_re = pmem_rd || (run && ((is_load && !to_pmem) || is_and_with_file));
  // Writing a file with d set reuses the read data in the same cycle
  assign mem_we = run && (is_store || (is_and_with_file && instr[`CIDD_DEST_BIT]));
  assign mem_wdata = is_and_with_file ? (w_reg & mem_rdata) : w_reg;

  // Ready only on the first cycle of each instruction
  assign instr_ready = state == ST_RUN && !standby;

  wire [7:0] and_lit = w_reg & lit8;
  wire [8:0] sum9 = {1'b0, w_reg} + {1'b0, lit8};
  wire [4:0] sum_nib = {1'b0, w_reg[`CIDD_NIB_HI:0]} + {1'b0, lit8[`CIDD_NIB_HI:0]};
  wire [7:0] and_file = w_reg & mem_rdata;

  genvar gi;
  generate
    for (gi = 0; gi < PORT_DIRECTION_REGISTER_N; gi = gi + 1) begin : g_dir
      assign port_dir_flat[8*gi +: 8] = port_dir[gi];
    end
  endgenerate

  // Wake comes from outside the instruction clock, so it is synchronised first
  reg wake_meta;
  reg wake_sync;
  always @(posedge clock) begin
    if (rst) begin
      wake_meta <= 1'b0;
      wake_sync <= 1'b0;
    end else begin
      wake_meta <= wake;
      wake_sync <= wake_meta;
    end
  end

  // Sequencer: program-memory access wins over the nop cycle
  always @(posedge clock) begin
    if (rst) begin
      state <= ST_RUN;
      pend_addr <= `CIDD_RST_PTR;
      pend_load <= 1'b0;
    end else begin
      case (state)
        ST_RUN: begin
          if (take) begin
            pend_addr <= eff_addr;
            pend_load <= is_load;
            if (to_pmem) begin
              state <= ST_PMEM;
            end else if (pc_mod || other_two_cycle) begin
              state <= ST_NOP;
            end
          end
        end
        ST_PMEM: begin
          pend_load <= 1'b0;
          state <= ST_RUN;
        end
        ST_NOP: begin
          state <= ST_RUN;
        end
        default: begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // Standby entry; no word is taken while asleep, so entry and wake never meet
  always @(posedge clock) begin
    if (rst) begin
      standby <= 1'b0;
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b1;
    end else if (take && is_sleep) begin
      standby <= 1'b1;
      timeout_flag <= 1'b1;
      powerdown_flag <= 1'b0;
    end else if (standby && wake_sync) begin
      standby <= 1'b0;
    end
  end

  // Stack wraps silently; deep nesting loses the oldest return address
  integer i;
  always @(posedge clock) begin
    if (rst) begin
      pc <= {PC_W{1'b0}};
      sp <= {SP_W{1'b0}};
      for (i = 0; i < (1 << SP_W); i = i + 1) begin
        stack[i] <= {PC_W{1'b0}};
      end
    end else if (take) begin
      if (is_brw) begin
        pc <= pc_inc + w_ext;
      end else if (is_call_by_accumulator) begin
        stack[sp] <= pc_inc;
        sp <= sp + SP_ONE;
        pc <= {pc_latch, w_reg};
      end else if (is_return_with_literal) begin
        pc <= stack[sp - SP_ONE];
        sp <= sp - SP_ONE;
      end else begin
        pc <= pc_inc;
      end
    end
  end

  // Pointer pairs
  always @(posedge clock) begin
    if (rst) begin
      fsr0 <= `CIDD_RST_PTR;
      fsr1 <= `CIDD_RST_PTR;
    end else if (take && ptr_write) begin
      if (mod_sel) begin
        fsr1 <= ptr_new;
      end else begin
        fsr0 <= ptr_new;
      end
    end
  end

  integer j;
  always @(posedge clock) begin
    if (rst) begin
      prescaler_cfg <= `CIDD_RST_PRESC;
      for (j = 0; j < PORT_DIRECTION_REGISTER_N; j = j + 1) begin
        port_dir[j] <= `CIDD_RST_PORT_DIRECTION_REGISTER;
      end
    end else if (take) begin
      if (is_option) begin
        prescaler_cfg <= w_reg;
      end
      if (is_port_direction_register) begin
        port_dir[instr[`CIDD_PORT_DIRECTION_REGISTER_HI:0]] <= w_reg;
      end
    end
  end

  // Working accumulator
  always @(posedge clock) begin
    if (rst) begin
      w_reg <= `CIDD_RST_BYTE;
    end else if (pmem_rd) begin
      w_reg <= mem_rdata;
    end else if (take) begin
      if (is_return_with_literal) begin
        w_reg <= lit8;
      end else if (is_load && !to_pmem) begin
        w_reg <= mem_rdata;
      end else if (is_and_immediate) begin
        w_reg <= and_lit;
      end else if (is_add_immediate) begin
        w_reg <= sum9[7:0];
      end else if (is_and_with_file && !instr[`CIDD_DEST_BIT]) begin
        w_reg <= and_file;
      end
    end
  end

  // Zero test on load, and_immediate, add_immediate and and_with_file results
  reg [7:0] zero_src;
  reg zero_upd;
  always @* begin
    zero_src = mem_rdata;
    zero_upd = 1'b0;
    if (pmem_rd) begin
      zero_upd = 1'b1;
    end else if (take) begin
      if (is_load && !to_pmem) begin
        zero_upd = 1'b1;
      end else if (is_and_immediate) begin
        zero_src = and_lit;
        zero_upd = 1'b1;
      end else if (is_add_immediate) begin
        zero_src = sum9[7:0];
        zero_upd = 1'b1;
      end else if (is_and_with_file) begin
        zero_src = and_file;
        zero_upd = 1'b1;
      end
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      zero_flag <= 1'b0;
    end else if (zero_upd) begin
      zero_flag <= zero_src == `CIDD_RST_BYTE;
    end
  end

  always @(posedge clock) begin
    if (rst) begin
      carry_flag <= 1'b0;
      digit_carry_flag <= 1'b0;
    end else if (take && is_add_immediate) begin
      carry_flag <= sum9[8];
      digit_carry_flag <= sum_nib[4];
    end
  end

endmodule // cidd_core

// file: cidd_core_asserts.sv
`timescale 1ns/10ps
module cidd_chk #(parameter PC_W = 15) (
  input wire clock,
  input wire rst,
  input wire instr_valid,
  input wire [13:0] instr,
  input wire instr_ready,
  input wire other_two_cycle,
  input wire [PC_W-1:0] pc,
  input wire [7:0] w_reg,
  input wire carry_flag,
  input wire zero_flag,
  input wire standby,
  input wire powerdown_flag,
  input wire [15:0] fsr0,
  input wire [7:0] prescaler_cfg,
  input wire mem_re,
  input wire mem_prog
);
  wire acc = instr_valid && instr_ready;
  wire [7:0] lit = instr[7:0];
  wire [15:0] k16 = {{10{instr[5]}}, instr[5:0]};
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  property p_brw; acc && instr == 14'h000B |=> (pc == $past(pc) + $past(w_reg) + 1 && !instr_ready)
    ##1 instr_ready; endproperty
  a_brw: assert property (p_brw) else $error("relative jump wrong");
  property p_opt; acc && instr == 14'h0062 |=> prescaler_cfg == $past(w_reg) && $stable(zero_flag);
  endproperty
  a_opt: assert property (p_opt) else $error("prescaler copy wrong");
  property p_slp; acc && instr == 14'h0063 |=> standby && !powerdown_flag && !instr_ready; endproperty
  a_slp: assert property (p_slp) else $error("standby entry wrong");
  property p_afp; acc && instr[13:6] == 8'hC4 |=> fsr0 == $past(fsr0) + $past(k16); endproperty
  a_afp: assert property (p_afp) else $error("pointer add wrong");
  property p_and; acc && instr[13:8] == 6'h39 |=> w_reg == ($past(w_reg) & $past(lit)) &&
    zero_flag == (w_reg == 8'h00) && $stable(carry_flag); endproperty
  a_and: assert property (p_and) else $error("literal and wrong");
  property p_add; acc && instr[13:8] == 6'h3E |=> {carry_flag, w_reg} == $past(w_reg) + $past(lit);
  endproperty
  a_add: assert property (p_add) else $error("literal add wrong");
  property p_two; acc && other_two_cycle |=> !instr_ready ##1 instr_ready; endproperty
  a_two: assert property (p_two) else $error("nop cycle wrong");
  property p_pm; mem_re && mem_prog |-> !instr_ready; endproperty
  a_pm: assert property (p_pm) else $error("program read not stalled");
  property p_one; acc && instr == 14'h0000 && !other_two_cycle |=> instr_ready; endproperty
  a_one: assert property (p_one) else $error("single cycle stalled");
  cover property (acc && instr == 14'h000B);
  cover property (mem_re && mem_prog);
  cover property (acc && other_two_cycle);
endmodule // cidd_chk
bind cidd_core cidd_chk #(.PC_W(PC_W)) chk_u (.clock(clock), .rst(rst),
  .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
  .other_two_cycle(other_two_cycle), .pc(pc), .w_reg(w_reg), .carry_flag(carry_flag),
  .zero_flag(zero_flag), .standby(standby), .powerdown_flag(powerdown_flag), .fsr0(fsr0),
  .prescaler_cfg(prescaler_cfg), .mem_re(mem_re), .mem_prog(mem_prog));

// file: cidd_tb.sv
`timescale 1ns/10ps
module testbench;
  reg clock = 0, rst = 1, instr_valid = 0, other_two_cycle = 0, wake = 0;
  reg [13:0] instr = 14'h0000;
  reg [6:0] pc_latch = 7'h12;
  reg [7:0] mem_rdata = 8'h00;
  wire instr_ready, mem_re, mem_we, mem_prog, carry_flag, digit_carry_flag, zero_flag;
  wire timeout_flag, powerdown_flag, standby;
  wire [15:0] mem_addr, fsr0, fsr1;
  wire [7:0] mem_wdata, w_reg, prescaler_cfg;
  wire [14:0] pc;
  wire [63:0] port_dir_flat;
  integer fail_count = 0, checked = 0;
  reg [14:0] p;
  reg [15:0] cap_addr;
  reg [7:0] cap_wdata;
  reg [2:0] cap_strb;
  cidd_core dut_u (.clock(clock), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .instr_ready(instr_ready), .other_two_cycle(other_two_cycle), .pc_latch(pc_latch),
    .wake(wake), .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_re(mem_re), .mem_we(mem_we), .mem_prog(mem_prog), .pc(pc), .w_reg(w_reg),
    .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag), .zero_flag(zero_flag),
    .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag), .standby(standby),
    .fsr0(fsr0), .fsr1(fsr1), .prescaler_cfg(prescaler_cfg), .port_dir_flat(port_dir_flat));
  initial forever #50 clock = ~clock;
  task tally_and_finish; begin
    if (fail_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  end endtask
  task chk(input [15:0] got, input [15:0] exp); begin
    checked = checked + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("mismatch %0t got %h exp %h", $time, got, exp);
    end
  end endtask
  // Returns at the falling edge after the word was taken; keeps the taking cycle's strobes
  task issue(input [13:0] op, input [7:0] rd = 8'h80, input oth = 1'b0);
    integer n; begin
    @(posedge clock);
    instr <= op; instr_valid <= 1'b1; mem_rdata <= rd; other_two_cycle <= oth;
    n = 0;
    @(negedge clock);
    while (instr_ready !== 1'b1 && n < 20) begin n = n + 1; @(negedge clock); end
    if (n == 20) begin fail_count = fail_count + 1; tally_and_finish; end
    cap_addr = mem_addr;
    cap_wdata = mem_wdata;
    cap_strb = {mem_re, mem_we, mem_prog};
    @(posedge clock);
    instr_valid <= 1'b0;
    @(negedge clock);
  end endtask
  task t_lit; begin
    issue(14'h3EF8); chk(w_reg, 16'h00F8);
    issue(14'h3E09); chk({carry_flag, digit_carry_flag, w_reg}, 16'h0301);
    issue(14'h39FE); chk({zero_flag, w_reg}, 16'h0100);
  end endtask
  task t_ctl; begin
    issue(14'h3E05); p = pc;
    issue(14'h000B); chk(instr_ready, 0); chk(pc, p + 6);
    @(negedge clock); chk(instr_ready, 1);
    p = pc;
    issue(14'h000A); chk(pc, 16'h1205);
    issue(14'h3477); chk(w_reg, 16'h0077); chk(pc, p + 1);
  end endtask
  task t_inh; begin
    issue(14'h0062); chk(prescaler_cfg, 16'h0077);
    issue(14'h0065); chk(port_dir_flat[47:40], 16'h0077);
    issue(14'h0064); chk(port_dir_flat[39:32], 16'h00FF);
    issue(14'h0063); chk({standby, timeout_flag, powerdown_flag, instr_ready}, 16'hC);
    @(posedge clock) wake <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock) chk(instr_ready, 0);
    @(posedge clock) wake <= 1'b0;
    @(negedge clock) chk(instr_ready, 1);
  end endtask
  task t_ptr; begin
    issue(14'h313F); chk(fsr0, 16'hFFFF);
    issue(14'h3101); chk(fsr0, 16'h0000);
    issue(14'h315F); chk(fsr1, 16'h001F);
    issue(14'h0014); chk({zero_flag, w_reg}, 16'h0080); chk(fsr1, 16'h0020);
    chk(cap_addr, 16'h0020); chk(cap_strb, 16'h0004);
    issue(14'h001F); chk(fsr1, 16'h001F); chk(zero_flag, 0);
    chk(cap_addr, 16'h0020); chk(cap_strb, 16'h0002); chk(cap_wdata, 16'h0080);
    issue(14'h3120); chk(fsr0, 16'hFFE0);
    issue(14'h3F00, 8'h00); chk(instr_ready, 0); chk(cap_strb, 16'h0001);
    chk({mem_re, mem_we, mem_prog}, 16'h0005); chk(mem_addr, 16'hFFE0);
    @(negedge clock); chk({zero_flag, w_reg, instr_ready}, 16'h0201);
    issue(14'h3FC1); chk(instr_ready, 1); chk(fsr1, 16'h001F);
    chk(cap_addr, 16'h0020); chk(cap_strb, 16'h0002);
    issue(14'h3E5A);
    issue(14'h0510, 8'h0F); chk({zero_flag, w_reg}, 16'h000A); chk(cap_strb, 16'h0004);
    issue(14'h0590, 8'h0F); chk({zero_flag, w_reg}, 16'h000A); chk(cap_wdata, 16'h000A);
    chk(cap_addr, 16'h0010); chk(cap_strb, 16'h0006);
    issue(14'h001E); chk(fsr1, 16'h0020); chk(cap_addr, 16'h001F);
    chk(cap_wdata, 16'h000A);
    issue(14'h0015, 8'hA5); chk(fsr1, 16'h001F); chk(cap_addr, 16'h001F);
    chk({zero_flag, w_reg}, 16'h00A5);
    issue(14'h0000, 8'h80, 1'b1); chk(instr_ready, 0);
    issue(14'h0000); chk(instr_ready, 1);
  end endtask
  initial begin
    repeat (4) @(posedge clock);
    rst <= 1'b0;
    t_lit;
    t_ctl;
    t_inh;
    t_ptr;
    tally_and_finish;
  end
endmodule // testbench
